/* File: rob_remote_out.sv */
/*
  Remote output block: two host-written data words steer output terminals
  that carry the remote function, under a retention policy for power cycles
  and inverter resets. rst_n_in stands for a power-up.
  Assumes the host link decodes parameter accesses into one-cycle strobes
  and that power_off_in comes early enough for two store writes.
*/
`include "rob_cfg.svh"
module rob_remote_out #(
  parameter int WORD_W = 12 // Bits per data word.
) (
  input  wire logic                    clock_in,       // 250 MHz clock.
  input  wire logic                    rst_n_in,       // Power-up reset, low.
  input  wire logic                    nv_clear_in,    // All-clear of the store.
  input  wire logic                    param_wr_in,    // Host write strobe.
  input  wire logic [1:0]              param_sel_in,   // Parameter select.
  input  wire logic [WORD_W-1:0]       param_wdata_in, // Host write data.
  input  wire logic                    power_off_in,   // Power failing pulse.
  input  wire logic                    inv_reset_in,   // Inverter reset pulse.
  input  wire logic [2*WORD_W*8-1:0]   func_sel_in,    // 8-bit code per terminal.
  input  wire logic [2*WORD_W-1:0]     func_level_in,  // Level of other functions.
  input  wire logic [2*WORD_W-1:0]     present_in,     // Terminal fitted.
  output logic      [2*WORD_W-1:0]     term_out,       // Terminal levels, 1 is on.
  output logic      [WORD_W-1:0]       param_rdata_out, // Selected parameter.
  output logic                         busy_out        // Host writes ignored.
);
  import rob_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations.
  // --------------------------------------------------------------------------
  localparam int NT = 2 * WORD_W; // Terminal count.

  rob_state_e        state_ff;     // Sequencer state.
  rob_state_e        nxt_state;    // Next sequencer state.
  logic [3:0]        mode_ff;      // Retention policy.
  logic [WORD_W-1:0] word1_ff;     // Data word one.
  logic [WORD_W-1:0] word2_ff;     // Data word two.
  logic [NT-1:0]     term_ff;      // Terminal levels.
  logic [WORD_W-1:0] rdata_ff;     // Read back register.
  logic              busy_ff;      // Sequencer busy.
  logic              mem_we;       // Store write strobe.
  logic [1:0]        mem_addr;     // Store address.
  logic [WORD_W-1:0] mem_wdata;    // Store write data.
  logic [WORD_W-1:0] mem_rdata;    // Store read data.
  logic              idle;         // Sequencer free.
  logic [NT-1:0]     data_bits;    // Both words as one terminal vector.
  logic              host_wr;      // Host write taken this cycle.
  logic              mode_wr;      // Legal policy write taken this cycle.
  if (WORD_W < 4)
  begin : g_width_check
    $error("rob_remote_out: word too narrow for the policy code");
  end

  // Policy keeps data across a power cycle.
  function automatic logic keep_pwr(input logic [3:0] m);
    keep_pwr = (m == `ROB_MODE_KEEP_PWR) || (m == `ROB_MODE_KEEP_BOTH);
  endfunction : keep_pwr

  // Policy keeps data across an inverter reset.
  function automatic logic keep_rst(input logic [3:0] m);
    keep_rst = (m == `ROB_MODE_KEEP_RST) || (m == `ROB_MODE_KEEP_BOTH);
  endfunction : keep_rst

  // Code is one of the four legal policies.
  function automatic logic mode_legal(input logic [3:0] m);
    mode_legal = keep_pwr(m) || keep_rst(m) || (m == `ROB_MODE_CLR_BOTH);
  endfunction : mode_legal

  assign idle      = (state_ff == ST_IDLE);
  assign data_bits = {word2_ff, word1_ff};
  assign host_wr   = idle && !power_off_in && !inv_reset_in && param_wr_in;
  assign mode_wr   = host_wr && (param_sel_in == `ROB_SEL_MODE)
                     && mode_legal(param_wdata_in[3:0]);

  // --------------------------------------------------------------------------
  // Nonvolatile store.
  // --------------------------------------------------------------------------
  rob_nv_store #(
    .WIDTH (WORD_W),
    .DEPTH (3),
    .AW    (2)
  ) u_store (
    .clock_in  (clock_in),
    .clear_in  (nv_clear_in),
    .we_in     (mem_we),
    .addr_in   (mem_addr),
    .wdata_in  (mem_wdata),
    .rdata_out (mem_rdata)
  );

  // Store port: reads during restore, saves at power-off, policy on write.
  always_comb
  begin
    mem_we    = 1'b0;
    mem_addr  = `ROB_SEL_MODE;
    mem_wdata = word1_ff;
    unique case (state_ff)
      RS_MODE: mem_addr = `ROB_SEL_MODE;
      RS_W1:   mem_addr = `ROB_SEL_WORD1;
      RS_W2:   mem_addr = `ROB_SEL_WORD2;
      RS_DONE: mem_addr = `ROB_SEL_MODE;
      SV_W2:
      begin
        mem_we    = 1'b1;
        mem_addr  = `ROB_SEL_WORD2;
        mem_wdata = word2_ff;
      end
      ST_IDLE:
      begin
        mem_we    = power_off_in ? keep_pwr(mode_ff) : mode_wr;
        mem_addr  = power_off_in ? `ROB_SEL_WORD1 : `ROB_SEL_MODE;
        mem_wdata = power_off_in ? word1_ff : {{(WORD_W-4){1'b0}}, param_wdata_in[3:0]};
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Sequencer.
  // --------------------------------------------------------------------------
  // Restore walks three slots; an inverter reset in mode 1 reuses it.
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      RS_MODE: nxt_state = RS_W1;
      RS_W1:   nxt_state = RS_W2;
      RS_W2:   nxt_state = RS_DONE;
      RS_DONE: nxt_state = ST_IDLE;
      SV_W2:   nxt_state = ST_IDLE;
      ST_IDLE: nxt_state = (power_off_in && keep_pwr(mode_ff)) ? SV_W2 :
                           (!power_off_in && inv_reset_in && keep_pwr(mode_ff)
                            && !keep_rst(mode_ff)) ? RS_MODE : ST_IDLE;
    endcase
  end

  // State register; power-up always starts with a restore.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= RS_MODE;
      busy_ff  <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state != ST_IDLE);
    end
  end

  // --------------------------------------------------------------------------
  // Policy and data words.
  // --------------------------------------------------------------------------
  // Illegal policy codes are dropped so the policy stays one of four.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_ff <= `ROB_MODE_RST;
    end
    else if (state_ff == RS_W1)
    begin
      mode_ff <= mode_legal(mem_rdata[3:0]) ? mem_rdata[3:0] : `ROB_MODE_RST;
    end
    else if (mode_wr)
    begin
      mode_ff <= param_wdata_in[3:0];
    end
  end

  // Word one: host writes go through only while the sequencer is idle and no
  // power-off or inverter reset pulse is present; there is no protection input.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      word1_ff <= `ROB_WORD_RST;
    end
    else if (state_ff == RS_W2)
    begin
      word1_ff <= keep_pwr(mode_ff) ? mem_rdata : `ROB_WORD_RST;
    end
    else if (idle && !power_off_in && inv_reset_in && !keep_rst(mode_ff)
             && !keep_pwr(mode_ff))
    begin
      word1_ff <= `ROB_WORD_RST;
    end
    else if (host_wr && (param_sel_in == `ROB_SEL_WORD1))
    begin
      word1_ff <= param_wdata_in;
    end
  end

  // Word two, same policy handling as word one.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      word2_ff <= `ROB_WORD_RST;
    end
    else if (state_ff == RS_DONE)
    begin
      word2_ff <= keep_pwr(mode_ff) ? mem_rdata : `ROB_WORD_RST;
    end
    else if (idle && !power_off_in && inv_reset_in && !keep_rst(mode_ff)
             && !keep_pwr(mode_ff))
    begin
      word2_ff <= `ROB_WORD_RST;
    end
    else if (host_wr && (param_sel_in == `ROB_SEL_WORD2))
    begin
      word2_ff <= param_wdata_in;
    end
  end

  // Read back of the selected parameter; the policy sits in the low bits.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_ff <= '0;
    end
    else
    begin
      unique case (param_sel_in)
        `ROB_SEL_MODE:  rdata_ff <= {{(WORD_W-4){1'b0}}, mode_ff};
        `ROB_SEL_WORD1: rdata_ff <= word1_ff;
        `ROB_SEL_WORD2: rdata_ff <= word2_ff;
        default:        rdata_ff <= '0;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Terminal drive.
  // --------------------------------------------------------------------------
  // Terminal 0 is the running-status terminal, driven by bit 0 of word one.
  // Absent terminals are held off whatever their bit says.
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      term_ff <= '0;
    end
    else
    begin
      for (int i = 0; i < NT; i++)
      begin
        term_ff[i] <= !present_in[i] ? 1'b0 :
                      (func_sel_in[i*8 +: 8] == `ROB_FUNC_POS) ? data_bits[i] :
                      (func_sel_in[i*8 +: 8] == `ROB_FUNC_NEG) ? ~data_bits[i] :
                      func_level_in[i];
      end
    end
  end

  assign term_out        = term_ff;
  assign param_rdata_out = rdata_ff;
  assign busy_out        = busy_ff;

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  a_mode_legal_only: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    mode_legal(mode_ff)) else $error("retention policy holds an illegal code");
  a_word_write_taken: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (idle && param_wr_in && !power_off_in && !inv_reset_in
     && param_sel_in == `ROB_SEL_WORD1) |=> (word1_ff == $past(param_wdata_in)))
    else $error("host write to word one was lost");
  a_pos_follow_bit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (present_in[0] && func_sel_in[7:0] == `ROB_FUNC_POS)
    |=> (term_out[0] == $past(word1_ff[0]))) else $error("positive terminal wrong");
  a_neg_invert_bit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (present_in[WORD_W] && func_sel_in[WORD_W*8 +: 8] == `ROB_FUNC_NEG)
    |=> (term_out[WORD_W] == !$past(word2_ff[0]))) else $error("negative terminal wrong");
  a_other_func_pass: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (present_in[1] && func_sel_in[15:8] != `ROB_FUNC_POS
     && func_sel_in[15:8] != `ROB_FUNC_NEG)
    |=> (term_out[1] == $past(func_level_in[1]))) else $error("non-remote terminal wrong");
  a_absent_held_off: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !present_in[2] |=> !term_out[2]) else $error("absent terminal driven");
  a_inv_clear_words: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (idle && inv_reset_in && !power_off_in && mode_ff == `ROB_MODE_CLR_BOTH)
    |=> (word1_ff == '0 && word2_ff == '0)) else $error("mode 0 reset kept data");
  a_inv_keep_words: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (idle && inv_reset_in && !power_off_in && keep_rst(mode_ff))
    |=> ($stable(word1_ff) && $stable(word2_ff) && state_ff == ST_IDLE))
    else $error("retaining reset changed data");
  a_save_two_writes: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (idle && power_off_in && keep_pwr(mode_ff))
    |-> (mem_we && mem_addr == `ROB_SEL_WORD1) ##1 (mem_we && mem_addr == `ROB_SEL_WORD2))
    else $error("power-off save did not write both words");
  a_restore_length: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_ff == RS_MODE) |-> ##4 (state_ff == ST_IDLE && !busy_out))
    else $error("restore did not finish in four cycles");
  a_powerup_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (state_ff == RS_W1 && !keep_pwr(mem_rdata[3:0])) |=> ##2 (word1_ff == '0 && word2_ff == '0))
    else $error("clearing policy restored data");
endmodule : rob_remote_out

/* File: rob_cfg.svh */
/*
  Constants of the remote output block: parameter select codes, storage
  slots, retention policy codes, terminal function codes and reset values.
  Assumes it is included by its bare name by the design and the bench.
*/
`ifndef ROB_CFG_SVH
`define ROB_CFG_SVH

// ----------------------------------------------------------------------------
// Parameter select codes, also the storage slot numbers.
// ----------------------------------------------------------------------------
`define ROB_SEL_MODE   2'h0
`define ROB_SEL_WORD1  2'h1
`define ROB_SEL_WORD2  2'h2

// ----------------------------------------------------------------------------
// Retention policy codes, held as their decimal value.
// ----------------------------------------------------------------------------
`define ROB_MODE_CLR_BOTH   4'h0
`define ROB_MODE_KEEP_PWR   4'h1
`define ROB_MODE_KEEP_RST   4'ha
`define ROB_MODE_KEEP_BOTH  4'hb
`define ROB_MODE_RST        4'h0

// ----------------------------------------------------------------------------
// Terminal function codes and reset values.
// ----------------------------------------------------------------------------
`define ROB_FUNC_POS   8'h60
`define ROB_FUNC_NEG   8'hc4
`define ROB_WORD_RST   12'h000

`endif

/* File: rob_pkg.sv */
/*
  Types of the remote output block: the sequencer state encoding.
  Assumes rob_cfg.svh is reachable on the include path.
*/
package rob_pkg;
  // --------------------------------------------------------------------------
  // Sequencer states.
  // --------------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    RS_MODE = 3'b000, // Read the stored policy.
    RS_W1   = 3'b001, // Policy arrives, read word one.
    RS_W2   = 3'b010, // Word one arrives, read word two.
    RS_DONE = 3'b011, // Word two arrives.
    ST_IDLE = 3'b100, // Normal operation.
    SV_W2   = 3'b101  // Second save write at power-off.
  } rob_state_e;
endpackage : rob_pkg

/* File: rob_nv_store.sv */
/*
  Small nonvolatile store for the remote output block: one port, write or
  registered read per cycle, plus a one-cycle clear of every slot.
  Assumes the storage survives the block reset, so it has no reset itself.
*/
module rob_nv_store #(
  parameter int WIDTH = 12, // Slot width.
  parameter int DEPTH = 3,  // Number of slots.
  parameter int AW    = 2   // Address width.
) (
  input  wire logic             clock_in,  // Block clock.
  input  wire logic             clear_in,  // Clears every slot to zero.
  input  wire logic             we_in,     // Write strobe.
  input  wire logic [AW-1:0]    addr_in,   // Slot address.
  input  wire logic [WIDTH-1:0] wdata_in,  // Write data.
  output logic      [WIDTH-1:0] rdata_out  // Read data, one cycle after address.
);
  // --------------------------------------------------------------------------
  // Storage.
  // --------------------------------------------------------------------------
  logic [WIDTH-1:0] mem_ff [DEPTH]; // Slots; kept across block resets.

  if (DEPTH > (1 << AW) || WIDTH < 1)
  begin : g_size_check
    $error("rob_nv_store: depth does not fit the address width");
  end

  // Clear wins over a write, since it stands for an all-parameter clear.
  always_ff @(posedge clock_in)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (clear_in)
      begin
        mem_ff[i] <= '0;
      end
      else if (we_in && (int'(addr_in) == i))
      begin
        mem_ff[i] <= wdata_in;
      end
    end
  end

  // Read data always come out of a register.
  always_ff @(posedge clock_in)
  begin
    rdata_out <= (int'(addr_in) < DEPTH) ? mem_ff[addr_in] : '0;
  end
endmodule : rob_nv_store

/* File: rob_load_model.sv */
/*
  Behavioural model of the loads wired to the output terminals of the
  remote output block. Assumes the terminals change on the same clock.
*/
module rob_load_model (
  input  wire logic        clock_in,   // Block clock.
  input  wire logic [23:0] term_in,    // Terminal levels, 1 is on.
  output logic      [23:0] load_on_out // Load energised state.
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Load pickup.
  // --------------------------------------------------------------------------
  // A load picks up one cycle after its terminal, so even a one-cycle
  // glitch on a terminal would show here.
  always_ff @(posedge clock_in)
  begin
    load_on_out <= term_in;
  end
endmodule : rob_load_model

/* File: tb_top.sv */
/*
  Self-checking bench of the remote output block, with a load model.
  Assumes rob_cfg.svh, the design files and rob_load_model.sv come first.
*/
`include "rob_cfg.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Signals.
  // --------------------------------------------------------------------------
  logic         clock_in, rst_n_in, nv_clear_in;   // Clock, power-up, store clear.
  logic         param_wr_in, power_off_in, inv_reset_in; // Host and event strobes.
  logic [1:0]   param_sel_in;                      // Parameter select.
  logic [11:0]  param_wdata_in, param_rdata_out;   // Host data.
  logic [191:0] func_sel_in;                       // Function codes.
  logic [23:0]  func_level_in, present_in;         // Own levels and fitting.
  logic [23:0]  term_out, load_on;                 // Terminals and loads.
  logic         busy_out;                          // Sequencer busy.
  int           error_cnt, checked;                // Mismatches and comparisons.

  rob_remote_out dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .nv_clear_in(nv_clear_in), .param_wr_in(param_wr_in),
    .param_sel_in(param_sel_in), .param_wdata_in(param_wdata_in),
    .power_off_in(power_off_in), .inv_reset_in(inv_reset_in),
    .func_sel_in(func_sel_in), .func_level_in(func_level_in),
    .present_in(present_in), .term_out(term_out),
    .param_rdata_out(param_rdata_out), .busy_out(busy_out));
  rob_load_model loads (.clock_in(clock_in), .term_in(term_out), .load_on_out(load_on));

  // --------------------------------------------------------------------------
  // Helpers.
  // --------------------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  // Expected terminal levels, worked out from the bench's own setup.
  function automatic logic [23:0] exp_term(input logic [11:0] w1, input logic [11:0] w2);
    logic [23:0] d;
    logic [23:0] r;
    d = {w2, w1};
    for (int i = 0; i < 24; i++)
    begin
      if (!present_in[i])
        r[i] = 1'b0;
      else if (func_sel_in[i*8 +: 8] == `ROB_FUNC_POS)
        r[i] = d[i];
      else if (func_sel_in[i*8 +: 8] == `ROB_FUNC_NEG)
        r[i] = ~d[i];
      else
        r[i] = func_level_in[i];
    end
    return r;
  endfunction : exp_term

  // One host write, held for exactly one sampling edge.
  task automatic wr(input logic [1:0] sel, input logic [11:0] data);
    @(posedge clock_in);
    param_wr_in    <= 1'b1;
    param_sel_in   <= sel;
    param_wdata_in <= data;
    @(posedge clock_in);
    param_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] sel, output logic [11:0] data);
    @(posedge clock_in);
    param_sel_in <= sel;
    @(posedge clock_in);
    #1;
    data = param_rdata_out;
  endtask : rd

  // Waits for the sequencer under a bounded count; a hang shows as busy.
  task automatic wait_idle;
    int n;
    n = 0;
    @(posedge clock_in);
    #1;
    while (busy_out !== 1'b0 && n < 40)
    begin
      @(posedge clock_in);
      #1;
      n++;
    end
    check("idle", {23'h0, busy_out}, 24'h0);
  endtask : wait_idle

  task automatic pulse(input bit off);
    @(posedge clock_in);
    power_off_in <= off;
    inv_reset_in <= !off;
    @(posedge clock_in);
    power_off_in <= 1'b0;
    inv_reset_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    wait_idle();
  endtask : pulse

  // Warning of power loss, then the supply really drops for two cycles.
  task automatic power_cycle;
    pulse(1'b1);
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    wait_idle();
  endtask : power_cycle

  task automatic chk_state(input logic [11:0] w1, input logic [11:0] w2);
    logic [11:0] v;
    rd(`ROB_SEL_WORD1, v);
    check("word one", {12'h0, v}, {12'h0, w1});
    rd(`ROB_SEL_WORD2, v);
    check("word two", {12'h0, v}, {12'h0, w2});
    check("terminals", term_out, exp_term(w1, w2));
    check("loads", load_on, exp_term(w1, w2));
  endtask : chk_state

  // --------------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------------
  task automatic t_policy;
    logic [3:0]  codes [4] = '{4'h0, 4'h1, 4'ha, 4'hb};
    logic [11:0] v;
    rd(`ROB_SEL_MODE, v);
    check("policy reset", {12'h0, v}, 24'h0);
    foreach (codes[k])
    begin
      wr(`ROB_SEL_MODE, {8'h0, codes[k]});
      rd(`ROB_SEL_MODE, v);
      check("policy", {12'h0, v}, {20'h0, codes[k]});
    end
    wr(`ROB_SEL_MODE, 12'h005);
    rd(`ROB_SEL_MODE, v);
    check("illegal policy", {12'h0, v}, 24'h00000b);
    wr(2'h3, 12'hfff);
    rd(2'h3, v);
    check("unmapped", {12'h0, v}, 24'h0);
    chk_state(12'h000, 12'h000);
  endtask : t_policy

  // A full-scale word one and the single running bit, each write one idle edge after the last.
  task automatic t_terms;
    wr(`ROB_SEL_WORD1, 12'hfff);
    wr(`ROB_SEL_WORD2, 12'ha5c);
    chk_state(12'hfff, 12'ha5c);
    wr(`ROB_SEL_WORD1, 12'h001);
    wr(`ROB_SEL_WORD2, 12'h000);
    chk_state(12'h001, 12'h000);
    check("running on", {23'h0, term_out[0]}, 24'h1);
  endtask : t_terms

  task automatic t_inv_reset;
    logic [3:0] modes [3] = '{4'h0, 4'ha, 4'hb};
    foreach (modes[k])
    begin
      wr(`ROB_SEL_MODE, {8'h0, modes[k]});
      wr(`ROB_SEL_WORD1, 12'h123);
      wr(`ROB_SEL_WORD2, 12'h456);
      pulse(1'b0);
      if (modes[k] == 4'h0)
        chk_state(12'h000, 12'h000);
      else
        chk_state(12'h123, 12'h456);
    end
  endtask : t_inv_reset

  // Power cycles in every policy, then an inverter reset that must reload
  // the words saved at the last power-off rather than the current ones.
  task automatic t_power;
    logic [3:0] modes [4] = '{4'h0, 4'h1, 4'ha, 4'hb};
    foreach (modes[k])
    begin
      wr(`ROB_SEL_MODE, {8'h0, modes[k]});
      wr(`ROB_SEL_WORD1, 12'h3c5);
      wr(`ROB_SEL_WORD2, 12'ha5a);
      power_cycle();
      if (modes[k][0])
        chk_state(12'h3c5, 12'ha5a);
      else
        chk_state(12'h000, 12'h000);
    end
    wr(`ROB_SEL_MODE, 12'h001);
    wr(`ROB_SEL_WORD1, 12'h111);
    wr(`ROB_SEL_WORD2, 12'h222);
    pulse(1'b0);
    chk_state(12'h3c5, 12'ha5a);
  endtask : t_power

  // --------------------------------------------------------------------------
  // Clock, watchdog and main sequence.
  // --------------------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  // The whole run needs a few hundred cycles; this leaves ample margin.
  initial
  begin
    #120000;
    error_cnt++;
    finish_test();
  end

  initial
  begin
    error_cnt = 0;
    checked = 0;
    rst_n_in = 1'b0;
    nv_clear_in = 1'b1;
    param_wr_in = 1'b0;
    power_off_in = 1'b0;
    inv_reset_in = 1'b0;
    param_sel_in = 2'h0;
    param_wdata_in = 12'h000;
    func_level_in = 24'h000006;
    present_in = 24'h7ffffb;
    for (int i = 0; i < 24; i++)
      func_sel_in[i*8 +: 8] = (i == 1 || i == 2) ? 8'h00 :
        ((i == 5 || i == 12) ? `ROB_FUNC_NEG : `ROB_FUNC_POS);
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    nv_clear_in <= 1'b0;
    wait_idle();
    chk_state(12'h000, 12'h000);
    t_policy();
    t_terms();
    t_inv_reset();
    t_power();
    finish_test();
  end
endmodule : tb_top
